// >>> inc/list_ptr_pkg.sv
// package: register map, field layout and carriers for the list pointer block
package list_ptr_pkg;

  // ***************************************************
  // register byte addresses
  // ***************************************************
  localparam logic [31:0] ctrl_cur_addr = 32'h30002c20;
  localparam logic [31:0] bulk_head_addr = 32'h30002c28;
  localparam logic [31:0] bulk_cur_addr = 32'h30002c2c;
  localparam logic [31:0] ctrl_head_addr = 32'h30002c24;
  localparam logic [31:0] list_ctl_addr = 32'h30002c40;

  // ***************************************************
  // field layout and reset values
  // ***************************************************
  localparam int ptr_lsb = 4;
  localparam logic [31:0] ptr_mask = 32'hfffffff0;
  localparam logic [31:0] ptr_reset = 32'h00000000;
  localparam logic [31:0] end_of_list = 32'h00000000;
  localparam int ctl_ctrl_en_bit = 0;
  localparam int ctl_bulk_en_bit = 1;
  localparam int ctl_ctrl_fill_bit = 2;
  localparam int ctl_bulk_fill_bit = 3;

  // engine events from the descriptor walker
  typedef struct packed {
    logic ctrl_advance;
    logic ctrl_end;
    logic bulk_advance;
    logic bulk_end;
    logic area_load;
    logic [31:0] next_ptr;
    logic [31:0] area_bulk_head;
  } walk_event_t;

  // pointers presented to the walker
  typedef struct packed {
    logic [31:0] ctrl_cur;
    logic [31:0] bulk_head;
    logic [31:0] bulk_cur;
  } walk_view_t;

endpackage

// >>> src/list_ptr_regs.sv
// list pointer registers for control and bulk descriptor lists
`timescale 1ns/1ps
// What this block does
// - the control current pointer lives in bits 31 to 4 and advances to the next descriptor.
// - the control current pointer is kept across frames so the walk resumes where it stopped.
// - at control list end a set pending flag reloads current from head and clears the flag.
// - the control current pointer resets to zero, which marks the end of the list.
// - the bulk walk starts at the bulk head pointer held in bits 31 to 4, reset zero.
// - the bulk head pointer is loaded from the shared communication area at init.
// - the bulk current pointer lives in bits 31 to 4 and advances after each descriptor.
// - the bulk current pointer is kept across frames so the walk resumes where it stopped.
// - at bulk list end a set pending flag reloads current from head and clears the flag.
// - the bulk current pointer resets to zero, which marks the end of the bulk list.
// - bulk descriptors are visited in their insertion order; the walk restarts at the head only when the bulk pending flag is set at list end.
module list_ptr_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire list_ptr_pkg::walk_event_t walk_i,
  output list_ptr_pkg::walk_view_t view_o,
  output logic control_queue_enable_o,
  output logic bulk_queue_enable_o
);

  // ***************************************************
  // state
  // ***************************************************
  logic [31:0] control_current_descriptor_ptr;
  logic [31:0] control_first_descriptor_ptr;
  logic [31:0] bulk_first_descriptor_ptr;
  logic [31:0] bulk_current_descriptor_ptr;
  logic control_queue_enable;
  logic bulk_queue_enable;
  logic control_queue_pending_flag;
  logic bulk_queue_pending_flag;
  logic [31:0] next_ctrl_cur;
  logic [31:0] next_ctrl_head;
  logic [31:0] next_bulk_head;
  logic [31:0] next_bulk_cur;
  logic next_ctrl_en;
  logic next_bulk_en;
  logic next_ctrl_fill;
  logic next_bulk_fill;
  logic [31:0] next_rdata;
  logic wr_stb;
  logic rd_stb;
  logic addr_hit;
  logic ctrl_fill_set;
  logic bulk_fill_set;

  // aligned pointer value, low nibble forced clear
  function automatic logic [31:0] align_ptr(input logic [31:0] v);
    align_ptr = v & list_ptr_pkg::ptr_mask;
  endfunction

  // address decode shared by write strobe and error answer
  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == list_ptr_pkg::ctrl_cur_addr) || (a == list_ptr_pkg::ctrl_head_addr) ||
                (a == list_ptr_pkg::bulk_head_addr) || (a == list_ptr_pkg::bulk_cur_addr) ||
                (a == list_ptr_pkg::list_ctl_addr);
  endfunction

  // ***************************************************
  // apb slave, zero wait states
  // ***************************************************
  assign pready_o = 1'b1;
  assign addr_hit = is_mapped(paddr_i);
  assign wr_stb = psel_i & penable_i & pwrite_i & addr_hit;
  assign rd_stb = psel_i & ~penable_i & ~pwrite_i;
  // unmapped access gets an error answer in the access phase
  assign pslverr_o = psel_i & penable_i & ~addr_hit;
  // software set of a pending flag; it must survive a reload in the same
  // cycle, otherwise a list filled just as the walker ends it is lost
  assign ctrl_fill_set = wr_stb && (paddr_i == list_ptr_pkg::list_ctl_addr) &&
                         pwdata_i[list_ptr_pkg::ctl_ctrl_fill_bit];
  assign bulk_fill_set = wr_stb && (paddr_i == list_ptr_pkg::list_ctl_addr) &&
                         pwdata_i[list_ptr_pkg::ctl_bulk_fill_bit];

  // read data is latched in setup so it comes from a flop
  always_comb begin
    next_rdata = prdata_o;
    if (rd_stb) begin
      case (paddr_i)
        list_ptr_pkg::ctrl_cur_addr: begin
          next_rdata = align_ptr(control_current_descriptor_ptr);
        end
        list_ptr_pkg::ctrl_head_addr: next_rdata = align_ptr(control_first_descriptor_ptr);
        list_ptr_pkg::bulk_head_addr: next_rdata = align_ptr(bulk_first_descriptor_ptr);
        list_ptr_pkg::bulk_cur_addr: next_rdata = align_ptr(bulk_current_descriptor_ptr);
        list_ptr_pkg::list_ctl_addr: begin
          next_rdata = 32'h00000000;
          next_rdata[list_ptr_pkg::ctl_ctrl_en_bit] = control_queue_enable;
          next_rdata[list_ptr_pkg::ctl_bulk_en_bit] = bulk_queue_enable;
          next_rdata[list_ptr_pkg::ctl_ctrl_fill_bit] = control_queue_pending_flag;
          next_rdata[list_ptr_pkg::ctl_bulk_fill_bit] = bulk_queue_pending_flag;
        end
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // ***************************************************
  // pointer and flag next state
  // ***************************************************
  // walker events win over software writes of the same pointer, since
  // software may only write a current pointer while its list is idle
  always_comb begin
    next_ctrl_cur = control_current_descriptor_ptr;
    next_ctrl_head = control_first_descriptor_ptr;
    next_bulk_head = bulk_first_descriptor_ptr;
    next_bulk_cur = bulk_current_descriptor_ptr;
    next_ctrl_en = control_queue_enable;
    next_bulk_en = bulk_queue_enable;
    next_ctrl_fill = control_queue_pending_flag;
    next_bulk_fill = bulk_queue_pending_flag;
    if (wr_stb) begin
      case (paddr_i)
        list_ptr_pkg::ctrl_cur_addr: begin
          if (!control_queue_enable) begin
            next_ctrl_cur = align_ptr(pwdata_i);
          end
        end
        list_ptr_pkg::ctrl_head_addr: next_ctrl_head = align_ptr(pwdata_i);
        list_ptr_pkg::bulk_head_addr: next_bulk_head = align_ptr(pwdata_i);
        list_ptr_pkg::bulk_cur_addr: begin
          if (!bulk_queue_enable) begin
            next_bulk_cur = align_ptr(pwdata_i);
          end
        end
        list_ptr_pkg::list_ctl_addr: begin
          next_ctrl_en = pwdata_i[list_ptr_pkg::ctl_ctrl_en_bit];
          next_bulk_en = pwdata_i[list_ptr_pkg::ctl_bulk_en_bit];
          // writing one sets a pending flag, zero leaves it
          next_ctrl_fill = control_queue_pending_flag | pwdata_i[list_ptr_pkg::ctl_ctrl_fill_bit];
          next_bulk_fill = bulk_queue_pending_flag | pwdata_i[list_ptr_pkg::ctl_bulk_fill_bit];
        end
        default: begin
        end
      endcase
    end
    if (walk_i.area_load) begin
      next_bulk_head = align_ptr(walk_i.area_bulk_head);
    end
    if (walk_i.ctrl_advance) begin
      next_ctrl_cur = align_ptr(walk_i.next_ptr);
    end else if (walk_i.ctrl_end && control_queue_pending_flag) begin
      next_ctrl_cur = control_first_descriptor_ptr;
      next_ctrl_fill = ctrl_fill_set;
    end
    if (walk_i.bulk_advance) begin
      next_bulk_cur = align_ptr(walk_i.next_ptr);
    end else if (walk_i.bulk_end && bulk_queue_pending_flag) begin
      next_bulk_cur = bulk_first_descriptor_ptr;
      next_bulk_fill = bulk_fill_set;
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      control_current_descriptor_ptr <= list_ptr_pkg::ptr_reset;
      control_first_descriptor_ptr <= list_ptr_pkg::ptr_reset;
      bulk_first_descriptor_ptr <= list_ptr_pkg::ptr_reset;
      bulk_current_descriptor_ptr <= list_ptr_pkg::ptr_reset;
      control_queue_enable <= 1'b0;
      bulk_queue_enable <= 1'b0;
      control_queue_pending_flag <= 1'b0;
      bulk_queue_pending_flag <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      control_current_descriptor_ptr <= next_ctrl_cur;
      control_first_descriptor_ptr <= next_ctrl_head;
      bulk_first_descriptor_ptr <= next_bulk_head;
      bulk_current_descriptor_ptr <= next_bulk_cur;
      control_queue_enable <= next_ctrl_en;
      bulk_queue_enable <= next_bulk_en;
      control_queue_pending_flag <= next_ctrl_fill;
      bulk_queue_pending_flag <= next_bulk_fill;
      prdata_o <= next_rdata;
    end
  end

  // ***************************************************
  // walker view
  // ***************************************************
  assign view_o.ctrl_cur = control_current_descriptor_ptr;
  assign view_o.bulk_head = bulk_first_descriptor_ptr;
  assign view_o.bulk_cur = bulk_current_descriptor_ptr;
  assign control_queue_enable_o = control_queue_enable;
  assign bulk_queue_enable_o = bulk_queue_enable;

  // ***************************************************
  // assertions
  // ***************************************************
  // reset leaves the control current, bulk head and bulk current pointers at the end marker
  property p_ctrl_reset_zero;
    @(posedge clk_i) $rose(reset_n_i) |->
      control_current_descriptor_ptr == list_ptr_pkg::end_of_list;
  endproperty
  a_ctrl_reset_zero: assert property (p_ctrl_reset_zero)
    else $error("control pointer not zero");

  property p_bulk_reset_zero;
    @(posedge clk_i) $rose(reset_n_i) |->
      bulk_current_descriptor_ptr == list_ptr_pkg::end_of_list &&
      bulk_first_descriptor_ptr == list_ptr_pkg::ptr_reset;
  endproperty
  a_bulk_reset_zero: assert property (p_bulk_reset_zero)
    else $error("bulk pointers not zero");

  // a refused write leaves the pointer untouched
  property p_ctrl_guard;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_stb && paddr_i == list_ptr_pkg::ctrl_cur_addr && control_queue_enable &&
      !walk_i.ctrl_advance && !walk_i.ctrl_end |=> $stable(control_current_descriptor_ptr);
  endproperty
  a_ctrl_guard: assert property (p_ctrl_guard)
    else $error("control pointer written while enabled");

  property p_bulk_guard;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_stb && paddr_i == list_ptr_pkg::bulk_cur_addr && bulk_queue_enable &&
      !walk_i.bulk_advance && !walk_i.bulk_end |=> $stable(bulk_current_descriptor_ptr);
  endproperty
  a_bulk_guard: assert property (p_bulk_guard)
    else $error("bulk pointer written while enabled");

  // end of list with the flag set reloads from the head; a software set
  // in that same cycle keeps the flag up for the next pass
  property p_ctrl_reload;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.ctrl_end && !walk_i.ctrl_advance && control_queue_pending_flag |=>
      control_current_descriptor_ptr == $past(control_first_descriptor_ptr) &&
      control_queue_pending_flag == $past(ctrl_fill_set);
  endproperty
  a_ctrl_reload: assert property (p_ctrl_reload)
    else $error("control reload missed");

  property p_bulk_reload;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.bulk_end && !walk_i.bulk_advance && bulk_queue_pending_flag |=>
      bulk_current_descriptor_ptr == $past(bulk_first_descriptor_ptr) &&
      bulk_queue_pending_flag == $past(bulk_fill_set);
  endproperty
  a_bulk_reload: assert property (p_bulk_reload)
    else $error("bulk reload missed");

  // end of list with the flag clear does nothing
  property p_ctrl_no_fill;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.ctrl_end && !walk_i.ctrl_advance && !control_queue_pending_flag && !wr_stb |=>
      $stable(control_current_descriptor_ptr);
  endproperty
  a_ctrl_no_fill: assert property (p_ctrl_no_fill)
    else $error("control end acted without flag");

  property p_bulk_no_fill;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.bulk_end && !walk_i.bulk_advance && !bulk_queue_pending_flag && !wr_stb |=>
      $stable(bulk_current_descriptor_ptr);
  endproperty
  a_bulk_no_fill: assert property (p_bulk_no_fill)
    else $error("bulk end acted without flag");

  // a software set of a pending flag is never lost
  property p_ctrl_fill_set;
    @(posedge clk_i) disable iff (!reset_n_i)
      ctrl_fill_set |=> control_queue_pending_flag;
  endproperty
  a_ctrl_fill_set: assert property (p_ctrl_fill_set)
    else $error("control pending set lost");

  property p_bulk_fill_set;
    @(posedge clk_i) disable iff (!reset_n_i)
      bulk_fill_set |=> bulk_queue_pending_flag;
  endproperty
  a_bulk_fill_set: assert property (p_bulk_fill_set)
    else $error("bulk pending set lost");

  // with no walker event and no write a pointer keeps its place across frames
  property p_ctrl_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !walk_i.ctrl_advance && !walk_i.ctrl_end &&
      !(wr_stb && paddr_i == list_ptr_pkg::ctrl_cur_addr) |=>
      $stable(control_current_descriptor_ptr);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control pointer moved on its own");

  property p_bulk_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !walk_i.bulk_advance && !walk_i.bulk_end &&
      !(wr_stb && paddr_i == list_ptr_pkg::bulk_cur_addr) |=>
      $stable(bulk_current_descriptor_ptr);
  endproperty
  a_bulk_hold: assert property (p_bulk_hold)
    else $error("bulk pointer moved on its own");

  // an advance loads the next descriptor address, low nibble cleared
  property p_ctrl_advance;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.ctrl_advance |=>
      control_current_descriptor_ptr == ($past(walk_i.next_ptr) & list_ptr_pkg::ptr_mask);
  endproperty
  a_ctrl_advance: assert property (p_ctrl_advance)
    else $error("control advance lost");

  property p_bulk_advance;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.bulk_advance |=>
      bulk_current_descriptor_ptr == ($past(walk_i.next_ptr) & list_ptr_pkg::ptr_mask);
  endproperty
  a_bulk_advance: assert property (p_bulk_advance)
    else $error("bulk advance lost");

  // bulk head load from the shared area wins over a software write
  property p_area_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      walk_i.area_load |=>
      bulk_first_descriptor_ptr == ($past(walk_i.area_bulk_head) & list_ptr_pkg::ptr_mask);
  endproperty
  a_area_load: assert property (p_area_load)
    else $error("bulk head load lost");

  // descriptors stay 16-byte aligned in the registers and on the bus
  property p_aligned;
    @(posedge clk_i) disable iff (!reset_n_i)
      (control_current_descriptor_ptr & ~list_ptr_pkg::ptr_mask) == list_ptr_pkg::ptr_reset &&
      (bulk_current_descriptor_ptr & ~list_ptr_pkg::ptr_mask) == list_ptr_pkg::ptr_reset &&
      (bulk_first_descriptor_ptr & ~list_ptr_pkg::ptr_mask) == list_ptr_pkg::ptr_reset;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("pointer not aligned");

  property p_rd_aligned;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_stb && paddr_i != list_ptr_pkg::list_ctl_addr |=>
      (prdata_o & ~list_ptr_pkg::ptr_mask) == list_ptr_pkg::ptr_reset;
  endproperty
  a_rd_aligned: assert property (p_rd_aligned)
    else $error("read data not aligned");

endmodule

// >>> bench/desc_walker_model.sv
// descriptor walker model: steps the lists and loads the bulk head
`timescale 1ns/1ps
module desc_walker_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic step_ctrl_i,
  input wire logic step_bulk_i,
  input wire logic init_i,
  input wire logic [31:0] init_head_i,
  input wire list_ptr_pkg::walk_view_t view_i,
  output list_ptr_pkg::walk_event_t walk_o
);
  // fixed chain 0x100 -> 0x200 -> 0x300 -> end, inserted in that order
  function automatic logic [31:0] link(input logic [31:0] p);
    return (p[11:8] == 4'h3) ? 32'h00000000 : p + 32'h00000100;
  endfunction
  // one-cycle events; idle data lines toggle so stale values never look valid
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      walk_o <= '0;
    end else begin
      walk_o <= '0;
      walk_o.next_ptr <= ~walk_o.next_ptr;
      walk_o.area_bulk_head <= init_i ? init_head_i : ~walk_o.area_bulk_head;
      walk_o.area_load <= init_i;
      if (step_bulk_i) begin
        walk_o.bulk_end <= (view_i.bulk_cur == 32'h00000000);
        walk_o.bulk_advance <= (view_i.bulk_cur != 32'h00000000);
        walk_o.next_ptr <= link(view_i.bulk_cur);
      end else if (step_ctrl_i) begin
        walk_o.ctrl_end <= (view_i.ctrl_cur == 32'h00000000);
        walk_o.ctrl_advance <= (view_i.ctrl_cur != 32'h00000000);
        walk_o.next_ptr <= link(view_i.ctrl_cur);
      end
    end
  end
endmodule

// >>> bench/list_ptr_regs_tb.sv
// self-checking bench for the list pointer registers
`timescale 1ns/1ps
module list_ptr_regs_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, prdata_o;
  logic pready_o, pslverr_o, ctrl_en_o, bulk_en_o;
  logic step_ctrl = 1'b0, step_bulk = 1'b0, init = 1'b0;
  logic [31:0] init_head = 32'h00000000;
  list_ptr_pkg::walk_event_t walk;
  list_ptr_pkg::walk_view_t view;
  int bad_count = 0, checked = 0, cycles = 0;
  logic [31:0] rd;
  logic err;

  list_ptr_regs list_ptr_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .walk_i(walk),
    .view_o(view), .control_queue_enable_o(ctrl_en_o), .bulk_queue_enable_o(bulk_en_o));
  desc_walker_model desc_walker_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .step_ctrl_i(step_ctrl), .step_bulk_i(step_bulk), .init_i(init), .init_head_i(init_head),
    .view_i(view), .walk_o(walk));

  // ***************************************************
  // clock, timeout and helpers
  // ***************************************************
  initial forever #50 clk_i = ~clk_i;
  // ceiling well above the roughly 160 cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer: hold request until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask
  // one walker step, then let the event and the view update land
  task automatic step(input logic bulk);
    @(posedge clk_i);
    step_bulk <= bulk;
    step_ctrl <= !bulk;
    @(posedge clk_i);
    step_bulk <= 1'b0;
    step_ctrl <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset();
    rchk(list_ptr_pkg::ctrl_cur_addr, 32'h00000000);
    rchk(list_ptr_pkg::bulk_head_addr, 32'h00000000);
    rchk(list_ptr_pkg::bulk_cur_addr, 32'h00000000);
    xfer(1'b0, 32'h30002c3c, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
  endtask
  task automatic t_head();
    xfer(1'b1, list_ptr_pkg::bulk_head_addr, 32'habcdef5f);
    rchk(list_ptr_pkg::bulk_head_addr, 32'habcdef50);
    @(posedge clk_i);
    init <= 1'b1;
    init_head <= 32'h0000010f;
    @(posedge clk_i);
    init <= 1'b0;
    repeat (3) @(posedge clk_i);
    rchk(list_ptr_pkg::bulk_head_addr, 32'h00000100);
  endtask
  task automatic t_bulk();
    xfer(1'b1, list_ptr_pkg::bulk_cur_addr, 32'h12345678);
    rchk(list_ptr_pkg::bulk_cur_addr, 32'h12345670);
    xfer(1'b1, list_ptr_pkg::bulk_cur_addr, 32'h00000000);
    xfer(1'b1, list_ptr_pkg::list_ctl_addr, 32'h0000000a);
    xfer(1'b1, list_ptr_pkg::bulk_cur_addr, 32'h00000700);
    rchk(list_ptr_pkg::bulk_cur_addr, 32'h00000000);
    step(1'b1);
    rchk(list_ptr_pkg::bulk_cur_addr, 32'h00000100);
    rchk(list_ptr_pkg::list_ctl_addr, 32'h00000002);
    // insertion order, then the end marker
    for (int i = 2; i <= 4; i++) begin
      step(1'b1);
      chk(view.bulk_cur, (i == 4) ? 32'h00000000 : 32'h00000100 * i);
    end
    step(1'b1);
    chk(view.bulk_cur, 32'h00000000);
    xfer(1'b1, list_ptr_pkg::list_ctl_addr, 32'h00000006);
    step(1'b1);
    chk(view.bulk_cur, 32'h00000000);
    rchk(list_ptr_pkg::list_ctl_addr, 32'h00000006);
  endtask
  task automatic t_ctrl();
    xfer(1'b1, list_ptr_pkg::list_ctl_addr, 32'h00000000);
    xfer(1'b1, list_ptr_pkg::ctrl_head_addr, 32'h00000400);
    xfer(1'b1, list_ptr_pkg::ctrl_cur_addr, 32'h0000000f);
    xfer(1'b1, list_ptr_pkg::list_ctl_addr, 32'h00000001);
    xfer(1'b1, list_ptr_pkg::ctrl_cur_addr, 32'h00000700);
    rchk(list_ptr_pkg::ctrl_cur_addr, 32'h00000000);
    step(1'b0);
    rchk(list_ptr_pkg::ctrl_cur_addr, 32'h00000400);
    rchk(list_ptr_pkg::list_ctl_addr, 32'h00000001);
    step(1'b0);
    chk(view.ctrl_cur, 32'h00000500);
    rchk(list_ptr_pkg::ctrl_cur_addr, 32'h00000500);
    xfer(1'b1, list_ptr_pkg::list_ctl_addr, 32'h00000000);
    xfer(1'b1, list_ptr_pkg::ctrl_cur_addr, 32'h00000000);
    step(1'b0);
    chk(view.ctrl_cur, 32'h00000000);
  endtask
  // a mid-run reset must bring the control current, bulk head and bulk current pointers back to the end marker
  task automatic t_again();
    xfer(1'b1, list_ptr_pkg::ctrl_cur_addr, 32'h00000800);
    xfer(1'b1, list_ptr_pkg::bulk_cur_addr, 32'h00000900);
    rchk(list_ptr_pkg::ctrl_cur_addr, 32'h00000800);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rchk(list_ptr_pkg::ctrl_cur_addr, 32'h00000000);
    rchk(list_ptr_pkg::bulk_head_addr, 32'h00000000);
    rchk(list_ptr_pkg::bulk_cur_addr, 32'h00000000);
  endtask

  task automatic end_of_test();
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_head();
    t_bulk();
    t_ctrl();
    t_again();
    end_of_test();
  end
endmodule
